// ==== cvl_pkg.sv ====
// Overview of operation
// RL1: Both registers reachable only in configuration state with index loaded.
// RL2: Power-on reset loads the validity register with 0x20.
// RL3: Validity bits 3 to 6 read 0,0,1,0 whatever is written.
// RL4: Software sets the validity flag itself; hardware just stores it.
// RL5: The validity flag drives no other hardware function.
// RL6: Power-on reset loads power/mode/lock register with 0x9C.
// RL7: Hard reset forces the lock bit to one, other bits kept.
// RL8: Power bit one keeps parallel port powered, zero puts it low-power.
// RL9: Mode bit one selects printer mode, zero defers to extended mode field.
// RL10: Lock bit one permits access to configuration registers 00 through 39.
// RL11: Lock bit zero blocks reads and writes of registers 00 through 39.
// RL12: Software cannot set a cleared lock bit; only resets restore it.
// RL13: Cleared power bit disables the logical device and its pins.
// RL14: Power-down leaves the host address decode of the device active.
// RL15: Address decode disabled only when base address programmed below 100h.
// RL16: Powered-down device at valid base keeps plug-and-play range checking.
// RL17: Extended mode field 00 selects standard and bidirectional modes.
// RL18: While locked, writes are dropped, reads return zero, state unchanged.
package cvl_pkg;

    // Bus widths
    localparam int IDX_W  = 8;
    localparam int DATA_W = 8;
    localparam int BASE_W = 16;
    localparam int EXT_W  = 2;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_VALID = 8'h00;
    localparam logic [IDX_W-1:0] IDX_PPML  = 8'h01;
    localparam logic [IDX_W-1:0] IDX_LAST  = 8'h39;

    // Power-on values
    localparam logic [DATA_W-1:0] VALID_POR = 8'h20;
    localparam logic [DATA_W-1:0] PPML_POR  = 8'h9C;

    // Read masks: stored bits and bits that read as constant ones
    localparam logic [DATA_W-1:0] VALID_RW_MASK = 8'h80;
    localparam logic [DATA_W-1:0] VALID_FIXED   = 8'h20;
    localparam logic [DATA_W-1:0] PPML_RW_MASK  = 8'h8C;
    localparam logic [DATA_W-1:0] PPML_FIXED    = 8'h10;

    // Field positions
    localparam int VALID_BIT   = 7;
    localparam int POWER_BIT   = 2;
    localparam int PRINTER_BIT = 3;
    localparam int LOCK_BIT    = 7;

    // Extended mode code for standard and bidirectional operation
    localparam logic [EXT_W-1:0] EXT_STD = 2'h0;

    // Lowest base address that keeps host decode alive
    localparam logic [BASE_W-1:0] MIN_DECODE_BASE = 16'h0100;

    // Zero word for blocked reads
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

endpackage

// ==== cvl_regs.sv ====
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module cvl_regs (
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire logic                           hard_rst_pin,
    input  wire logic                           cfg_mode,
    input  wire logic [cvl_pkg::IDX_W-1:0]      cfg_index,
    input  wire logic [cvl_pkg::DATA_W-1:0]     wdata,
    input  wire logic                           wr_stb,
    input  wire logic                           rd_stb,
    input  wire logic [cvl_pkg::EXT_W-1:0]      misc_ext_mode,
    input  wire logic [cvl_pkg::BASE_W-1:0]     pport_base_addr,
    output logic [cvl_pkg::DATA_W-1:0]          rdata_ff,
    output logic                                rd_valid_ff,
    output logic                                cfg_unlocked_ff,
    output logic                                ext_wr_en_ff,
    output logic                                ext_rd_en_ff,
    output logic [cvl_pkg::IDX_W-1:0]           ext_index_ff,
    output logic [cvl_pkg::DATA_W-1:0]          ext_wdata_ff,
    output logic                                pport_power_ff,
    output logic                                pport_pins_en_ff,
    output logic                                pport_printer_ff,
    output logic [cvl_pkg::EXT_W-1:0]           pport_ext_mode_ff,
    output logic                                pport_decode_en_ff,
    output logic                                pport_pnp_check_ff
);
    import cvl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic               hrst_meta_ff;
    logic               hrst_sync_ff;
    logic               valid_bit_ff;
    logic               power_bit_ff;
    logic               printer_bit_ff;
    logic               lock_bit_ff;
    logic               open_acc;
    logic               wr_hit;
    logic               rd_hit;
    logic               wr_valid;
    logic               wr_ppml;
    logic               nxt_lock;
    logic [DATA_W-1:0]  nxt_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Gate shared by the read and write paths
    function automatic logic cfg_open(input logic             in_cfg,
                                      input logic             unlocked,
                                      input logic [IDX_W-1:0] idx);
        cfg_open = in_cfg && unlocked && (idx <= IDX_LAST); // RL1
    endfunction

    // Image of a register: stored bits masked in, fixed bits forced
    function automatic logic [DATA_W-1:0] reg_image(input logic [DATA_W-1:0] stored,
                                                    input logic [DATA_W-1:0] rw_mask,
                                                    input logic [DATA_W-1:0] fixed);
        reg_image = (stored & rw_mask) | fixed;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Hard reset pin synchroniser

    // Pin is asynchronous to mclk, so two flops before any use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrst_meta_ff <= 1'b0;
            hrst_sync_ff <= 1'b0;
        end else if (ce) begin
            hrst_meta_ff <= hard_rst_pin;
            hrst_sync_ff <= hrst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    // Only a full index match with the lock open reaches storage
    always_comb begin
        open_acc = cfg_open(cfg_mode, lock_bit_ff, cfg_index);
        wr_hit   = wr_stb && open_acc;   // RL10
        rd_hit   = rd_stb && open_acc;   // RL10
        wr_valid = wr_hit && (cfg_index == IDX_VALID); // RL1
        wr_ppml  = wr_hit && (cfg_index == IDX_PPML);  // RL1
    end

    ////////////////////////////////////////////////////////////////////////////
    // Validity flag

    // Plain storage bit; only the read path reads it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            valid_bit_ff <= VALID_POR[VALID_BIT]; // RL2
        end else if (ce && wr_valid) begin
            valid_bit_ff <= wdata[VALID_BIT]; // RL4 RL5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power and mode bits

    // Hard reset leaves these alone; only the lock reacts to it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_bit_ff   <= PPML_POR[POWER_BIT];   // RL6
            printer_bit_ff <= PPML_POR[PRINTER_BIT]; // RL6
        end else if (ce && wr_ppml) begin
            power_bit_ff   <= wdata[POWER_BIT];      // RL8
            printer_bit_ff <= wdata[PRINTER_BIT];    // RL9
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock bit

    // Software may only clear; a write of one cannot revive it
    always_comb begin
        nxt_lock = lock_bit_ff;
        if (hrst_sync_ff) begin
            nxt_lock = 1'b1; // RL7
        end else if (wr_ppml) begin
            nxt_lock = lock_bit_ff & wdata[LOCK_BIT]; // RL12
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_bit_ff <= PPML_POR[LOCK_BIT]; // RL6
        end else if (ce) begin
            lock_bit_ff <= nxt_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Blocked or foreign indices read zero here; the other bank answers its own
    always_comb begin
        nxt_rdata = DATA_ZERO; // RL11 RL18
        if (rd_hit) begin
            if (cfg_index == IDX_VALID) begin
                nxt_rdata = reg_image({valid_bit_ff, 7'h00}, VALID_RW_MASK, VALID_FIXED); // RL3
            end else if (cfg_index == IDX_PPML) begin
                nxt_rdata = reg_image({lock_bit_ff, 3'h0, printer_bit_ff, power_bit_ff, 2'h0},
                                      PPML_RW_MASK, PPML_FIXED);
            end
        end
    end

    // Data stand one cycle only, then fall back to zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff    <= DATA_ZERO;
            rd_valid_ff <= 1'b0;
        end else if (ce) begin
            rdata_ff    <= nxt_rdata;
            rd_valid_ff <= rd_stb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Grants to the rest of the configuration bank

    // Other registers up to index 39 see strobes only while unlocked
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_wr_en_ff    <= 1'b0;
            ext_rd_en_ff    <= 1'b0;
            ext_index_ff    <= IDX_VALID;
            ext_wdata_ff    <= DATA_ZERO;
            cfg_unlocked_ff <= PPML_POR[LOCK_BIT];
        end else if (ce) begin
            ext_wr_en_ff    <= wr_hit && (cfg_index > IDX_PPML); // RL10 RL11
            ext_rd_en_ff    <= rd_hit && (cfg_index > IDX_PPML); // RL10 RL11
            ext_index_ff    <= cfg_index;
            ext_wdata_ff    <= wdata;
            cfg_unlocked_ff <= nxt_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel port controls

    // Power gates the pins but never the address decode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pport_power_ff     <= PPML_POR[POWER_BIT];
            pport_pins_en_ff   <= PPML_POR[POWER_BIT];
            pport_printer_ff   <= PPML_POR[PRINTER_BIT];
            pport_ext_mode_ff  <= EXT_STD;
            pport_decode_en_ff <= 1'b0;
            pport_pnp_check_ff <= 1'b0;
        end else if (ce) begin
            pport_power_ff     <= power_bit_ff;   // RL8
            pport_pins_en_ff   <= power_bit_ff;   // RL13
            pport_printer_ff   <= printer_bit_ff; // RL9
            pport_ext_mode_ff  <= printer_bit_ff ? EXT_STD : misc_ext_mode; // RL9 RL17
            pport_decode_en_ff <= (pport_base_addr >= MIN_DECODE_BASE);     // RL14 RL15
            pport_pnp_check_ff <= (pport_base_addr >= MIN_DECODE_BASE);     // RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_lock_never_set: assert property ( // RL12
        (ce && !lock_bit_ff && !hrst_sync_ff) |=> !lock_bit_ff)
        else $error("cleared lock came back without reset");

    a_hard_sets_lock: assert property ( // RL7
        (ce && hrst_sync_ff) |=> (lock_bit_ff && cfg_unlocked_ff))
        else $error("hard reset did not force lock high");

    a_hard_keeps_bits: assert property ( // RL7
        (ce && hrst_sync_ff && !wr_ppml) |=> ($stable(power_bit_ff) && $stable(printer_bit_ff)))
        else $error("hard reset disturbed power or mode bits");

    a_pin_to_lock: assert property ( // RL7
        (ce && hard_rst_pin) ##1 ce ##1 ce |=> lock_bit_ff)
        else $error("hard reset pin not seen in three cycles");

    a_locked_read_zero: assert property ( // RL11
        (ce && rd_stb && !lock_bit_ff) |=> (rdata_ff == DATA_ZERO && rd_valid_ff && !ext_rd_en_ff))
        else $error("read while locked returned data");

    a_locked_write_drop: assert property ( // RL18
        (ce && wr_stb && !lock_bit_ff) |=>
            ($stable(valid_bit_ff) && $stable(power_bit_ff) && $stable(printer_bit_ff) && !ext_wr_en_ff))
        else $error("write while locked changed state");

    a_cfg_state_gate: assert property ( // RL1
        (ce && wr_stb && !cfg_mode) |=> ($stable(valid_bit_ff) && $stable(power_bit_ff) && !ext_wr_en_ff))
        else $error("write outside configuration state took effect");

    a_valid_fixed_bits: assert property ( // RL3
        (ce && rd_hit && cfg_index == IDX_VALID) |=> (rdata_ff[6:0] == VALID_FIXED[6:0]))
        else $error("validity reserved bits read wrong");

    a_ppml_readback: assert property ( // RL8
        (ce && wr_ppml && wdata[LOCK_BIT]) ##1 (ce && rd_hit && cfg_index == IDX_PPML) |=>
            (rdata_ff == ((($past(wdata, 2)) & PPML_RW_MASK) | PPML_FIXED)))
        else $error("power and mode register read back wrong");

    a_pins_follow_power: assert property ( // RL13
        (ce && !power_bit_ff) |=> (!pport_pins_en_ff && !pport_power_ff))
        else $error("pins enabled while powered down");

    a_decode_low_base: assert property ( // RL15
        (ce && pport_base_addr < MIN_DECODE_BASE) |=> (!pport_decode_en_ff && !pport_pnp_check_ff))
        else $error("decode alive with base below minimum");

    a_decode_when_off: assert property ( // RL14
        (ce && !power_bit_ff && pport_base_addr >= MIN_DECODE_BASE) |=>
            (pport_decode_en_ff && pport_pnp_check_ff && !pport_pins_en_ff))
        else $error("power down removed address decode");

    a_ext_mode_sel: assert property ( // RL9
        (ce && !printer_bit_ff) |=> (pport_ext_mode_ff == $past(misc_ext_mode) && !pport_printer_ff))
        else $error("extended mode not taken from field");

    a_printer_std: assert property ( // RL17
        (ce && printer_bit_ff) |=> (pport_ext_mode_ff == EXT_STD && pport_printer_ff))
        else $error("printer mode did not force standard code");

    a_valid_store: assert property ( // RL4
        (ce && wr_valid) |=> (valid_bit_ff == $past(wdata[VALID_BIT])))
        else $error("validity flag did not store written value");

    a_freeze_ce: assert property (
        (!ce) |=> ($stable(lock_bit_ff) && $stable(rdata_ff) && $stable(power_bit_ff)))
        else $error("state moved with clock enable low");

    ////////////////////////////////////////////////////////////////////////////
    // Read path checks

    // Read data must not linger, or a stale word looks like a fresh answer
    a_rdata_idle_zero: assert property (
        (ce && !rd_stb) |=> (rdata_ff == DATA_ZERO && !rd_valid_ff))
        else $error("read data stood without a read strobe");

    a_rd_valid_pulse: assert property ( // RL18
        (ce && rd_stb) |=> rd_valid_ff)
        else $error("read strobe got no valid pulse");

    a_valid_read_bit: assert property ( // RL5
        (ce && rd_hit && cfg_index == IDX_VALID) |=> (rdata_ff[VALID_BIT] == valid_bit_ff))
        else $error("validity flag read back wrong");

    a_ppml_fixed_bits: assert property ( // RL6
        (ce && rd_hit && cfg_index == IDX_PPML) |=>
            ((rdata_ff & ~PPML_RW_MASK) == PPML_FIXED))
        else $error("power and mode reserved bits read wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Grant checks

    a_far_index_block: assert property ( // RL10
        (ce && (wr_stb || rd_stb) && cfg_index > IDX_LAST) |=>
            (!ext_wr_en_ff && !ext_rd_en_ff && rdata_ff == DATA_ZERO))
        else $error("index beyond the bank was granted");

    a_open_wr_grant: assert property ( // RL10
        (ce && wr_stb && cfg_mode && lock_bit_ff && cfg_index > IDX_PPML && cfg_index <= IDX_LAST) |=>
            ext_wr_en_ff)
        else $error("open write to other bank not granted");

    a_open_rd_grant: assert property ( // RL10
        (ce && rd_stb && cfg_mode && lock_bit_ff && cfg_index > IDX_PPML && cfg_index <= IDX_LAST) |=>
            ext_rd_en_ff)
        else $error("open read of other bank not granted");

    // Index and data must line up with the grant pulse of the same cycle
    a_grant_capture: assert property ( // RL10
        ce |=> (ext_index_ff == $past(cfg_index) && ext_wdata_ff == $past(wdata)))
        else $error("grant index or data not captured");

    ////////////////////////////////////////////////////////////////////////////
    // Lock, storage and port output checks

    a_unlock_mirror: assert property ( // RL11
        cfg_unlocked_ff == lock_bit_ff)
        else $error("unlock output differs from lock bit");

    a_lock_clear_takes: assert property ( // RL11
        (ce && wr_ppml && !wdata[LOCK_BIT] && !hrst_sync_ff) |=> (!lock_bit_ff && !cfg_unlocked_ff))
        else $error("lock clear write did not close the bank");

    a_valid_write_iso: assert property ( // RL5
        (ce && wr_valid && !hrst_sync_ff) |=>
            ($stable(power_bit_ff) && $stable(printer_bit_ff) && $stable(lock_bit_ff)))
        else $error("validity write touched other controls");

    a_ppml_keeps_valid: assert property ( // RL5
        (ce && wr_ppml) |=> $stable(valid_bit_ff))
        else $error("power and mode write touched validity flag");

    a_power_store: assert property ( // RL9
        (ce && wr_ppml) |=>
            (power_bit_ff == $past(wdata[POWER_BIT]) && printer_bit_ff == $past(wdata[PRINTER_BIT])))
        else $error("power or mode bit did not store written value");

    a_power_on_follow: assert property ( // RL8
        (ce && power_bit_ff) |=> (pport_power_ff && pport_pins_en_ff))
        else $error("port not powered with power bit set");

    a_decode_high_base: assert property ( // RL16
        (ce && pport_base_addr >= MIN_DECODE_BASE) |=> (pport_decode_en_ff && pport_pnp_check_ff))
        else $error("decode lost with valid base");

endmodule

// ==== cvl_regs_tb.sv ====
`timescale 1ns/1ps
module cvl_regs_tb;
    import cvl_pkg::*;

    logic              mclk;
    logic              rst;
    logic              ce;
    logic              hard_rst_pin;
    logic              cfg_mode;
    logic [7:0]        cfg_index;
    logic [7:0]        wdata;
    logic              wr_stb;
    logic              rd_stb;
    logic [1:0]        misc_ext_mode;
    logic [15:0]       pport_base_addr;
    logic [7:0]        rdata_ff;
    logic              rd_valid_ff;
    logic              cfg_unlocked_ff;
    logic              ext_wr_en_ff;
    logic              ext_rd_en_ff;
    logic              pport_power_ff;
    logic              pport_pins_en_ff;
    logic              pport_printer_ff;
    logic [1:0]        pport_ext_mode_ff;
    logic              pport_decode_en_ff;
    logic              pport_pnp_check_ff;
    logic [7:0]        ext_index_ff;
    logic [7:0]        ext_wdata_ff;
    int                err_count;
    int                cmp_count;
    int                n;
    logic [7:0]        q;
    logic [7:0]        d;
    logic              g;
    logic              vbit;
    logic [15:0]       b;

    cvl_regs uut (
        .mclk(mclk), .rst(rst), .ce(ce), .hard_rst_pin(hard_rst_pin), .cfg_mode(cfg_mode),
        .cfg_index(cfg_index), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .misc_ext_mode(misc_ext_mode), .pport_base_addr(pport_base_addr), .rdata_ff(rdata_ff),
        .rd_valid_ff(rd_valid_ff), .cfg_unlocked_ff(cfg_unlocked_ff), .ext_wr_en_ff(ext_wr_en_ff),
        .ext_rd_en_ff(ext_rd_en_ff), .ext_index_ff(ext_index_ff), .ext_wdata_ff(ext_wdata_ff),
        .pport_power_ff(pport_power_ff),
        .pport_pins_en_ff(pport_pins_en_ff), .pport_printer_ff(pport_printer_ff),
        .pport_ext_mode_ff(pport_ext_mode_ff), .pport_decode_en_ff(pport_decode_en_ff),
        .pport_pnp_check_ff(pport_pnp_check_ff));

    // 125 MHz clock
    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; grant sampled once the edge has landed
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat, output logic gnt);
        @(posedge mclk);
        cfg_index <= idx;
        wdata <= dat;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1 gnt = ext_wr_en_ff;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] idx, output logic [7:0] dat, output logic gnt);
        @(posedge mclk);
        cfg_index <= idx;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        dat = rdata_ff;
        gnt = ext_rd_en_ff;
        chk({7'h0, rd_valid_ff}, 8'h01);
    endtask

    // Write then read with no gap; the read must see the new value
    task automatic wr_rd(input logic [7:0] idx, input logic [7:0] dat, output logic [7:0] got);
        @(posedge mclk);
        cfg_index <= idx;
        wdata <= dat;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        got = rdata_ff;
        chk({7'h0, rd_valid_ff}, 8'h01);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 0; rst = 1; ce = 1; hard_rst_pin = 0; cfg_mode = 1; cfg_index = 0; wdata = 0;
        wr_stb = 0; rd_stb = 0; misc_ext_mode = 0; pport_base_addr = 0;
        err_count = 0;
        cmp_count = 0;
        vbit = 0;
        void'($urandom(36));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        idle(2);
        rd(IDX_VALID, q, g); chk(q, 8'h20);
        rd(IDX_PPML, q, g); chk(q, 8'h9C);
        // Validity flag: corners first, then random; other fields fixed
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            vbit = d[7];
            wr(IDX_VALID, d, g);
            rd(IDX_VALID, q, g); chk(q, {vbit, 7'h20});
            chk({7'h0, pport_power_ff}, 8'h01);
        end
        // Power and mode bits with every extended code, base on both sides of 100h
        for (int i = 0; i < 16; i++) begin
            d = {1'b1, 7'($urandom)};
            d[3:2] = 2'(i);
            b = (i == 0) ? 16'h00FF : (i == 1) ? 16'h0100 : 16'($urandom);
            misc_ext_mode <= 2'(i >> 2);
            pport_base_addr <= b;
            wr_rd(IDX_PPML, d, q); chk(q, (d & 8'h8C) | 8'h10);
            idle(2);
            chk({7'h0, pport_power_ff}, {7'h0, d[2]});
            chk({7'h0, pport_pins_en_ff}, {7'h0, d[2]});
            chk({7'h0, pport_printer_ff}, {7'h0, d[3]});
            chk({6'h0, pport_ext_mode_ff}, d[3] ? 8'h00 : 8'(i >> 2));
            chk({7'h0, pport_decode_en_ff}, {7'h0, b >= 16'h0100});
            chk({7'h0, pport_pnp_check_ff}, {7'h0, b >= 16'h0100});
        end
        // Other bank reaches up to index 39 and no further
        wr(8'h02, 8'h5A, g); chk({7'h0, g}, 8'h01);
        chk(ext_index_ff, 8'h02);
        chk(ext_wdata_ff, 8'h5A);
        wr(8'h39, 8'hA5, g); chk({7'h0, g}, 8'h01);
        wr(8'h3A, 8'hA5, g); chk({7'h0, g}, 8'h00);
        rd(8'h39, q, g); chk({7'h0, g}, 8'h01);
        // Outside configuration state nothing is reached
        cfg_mode <= 1'b0;
        wr(IDX_VALID, {~vbit, 7'h00}, g);
        rd(IDX_VALID, q, g); chk(q, 8'h00);
        wr(8'h10, 8'h11, g); chk({7'h0, g}, 8'h00);
        cfg_mode <= 1'b1;
        rd(IDX_VALID, q, g); chk(q, {vbit, 7'h20});
        // Clearing the lock closes the whole bank
        wr(IDX_PPML, 8'h08, g); chk({7'h0, cfg_unlocked_ff}, 8'h00);
        rd(IDX_VALID, q, g); chk(q, 8'h00);
        wr(IDX_PPML, 8'h84, g);
        wr(8'h10, 8'h33, g); chk({7'h0, g}, 8'h00);
        chk({7'h0, cfg_unlocked_ff}, 8'h00);
        idle(2);
        chk({7'h0, pport_power_ff}, 8'h00);
        // Hard reset restores the lock alone; the wait is bounded
        @(posedge mclk);
        hard_rst_pin <= 1'b1;
        n = 0;
        while (cfg_unlocked_ff !== 1'b1 && n < 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 10) begin
            err_count++;
            final_report();
        end
        hard_rst_pin <= 1'b0;
        idle(4);
        rd(IDX_PPML, q, g); chk(q, 8'h98);
        rd(IDX_VALID, q, g); chk(q, {vbit, 7'h20});
        // Frozen clock enable drops a write
        ce <= 1'b0;
        wr(IDX_VALID, {~vbit, 7'h00}, g);
        ce <= 1'b1;
        rd(IDX_VALID, q, g); chk(q, {vbit, 7'h20});
        // Power-on reset after a lock clear reopens everything
        wr(IDX_PPML, 8'h00, g);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(2);
        rd(IDX_PPML, q, g); chk(q, 8'h9C);
        rd(IDX_VALID, q, g); chk(q, 8'h20);
        final_report();
    end
endmodule
